// file: include/dda_pkg.sv
package dda_pkg;

    // Clock and timing figures; cycle counts are derived from the clock rate.
    localparam int unsigned CLK_MHZ          = 40;
    localparam int unsigned CC_DEBOUNCE_US   = 150000;
    localparam int unsigned PD_DEBOUNCE_US   = 15000;
    localparam int unsigned DRP_TRY_US       = 100000;
    localparam int unsigned TOGGLE_US        = 75000;
    localparam int unsigned CC_DEBOUNCE_CYC  = CC_DEBOUNCE_US * CLK_MHZ;
    localparam int unsigned PD_DEBOUNCE_CYC  = PD_DEBOUNCE_US * CLK_MHZ;
    localparam int unsigned DRP_TRY_CYC      = DRP_TRY_US * CLK_MHZ;
    localparam int unsigned TOGGLE_CYC       = TOGGLE_US * CLK_MHZ;

    // Termination placed on one CC pin. Rp codes carry the offered current.
    typedef enum logic [2:0]
    {
        TERM_OPEN   = 3'h0,
        TERM_RD     = 3'h1,
        TERM_RD_ALT = 3'h2,
        TERM_RP_DEF = 3'h4,
        TERM_RP_1A5 = 3'h5,
        TERM_RP_3A0 = 3'h6
    } dda_term_t;

    localparam logic [1:0] CUR_NONE = 2'h0;
    localparam logic [1:0] CUR_DEF  = 2'h1;
    localparam logic [1:0] CUR_1A5  = 2'h2;
    localparam logic [1:0] CUR_3A0  = 2'h3;
    localparam logic [2:0] RESET_STATE = 3'h0;

    typedef enum logic [2:0]
    {
        DTS_UNATT_SRC   = 3'h0,
        DTS_ATTWAIT_SRC = 3'h1,
        DTS_ATT_SRC     = 3'h3,
        DTS_UNATT_SNK   = 3'h2,
        DTS_ATTWAIT_SNK = 3'h6,
        DTS_TRY_SRC     = 3'h7,
        DTS_TRYWAIT_SNK = 3'h5,
        DTS_ATT_SNK     = 3'h4
    } dda_dts_state_t;

    typedef enum logic [2:0]
    {
        TS_UNATT_SRC   = 3'h0,
        TS_ATTWAIT_SRC = 3'h1,
        TS_UNOR_SRC    = 3'h3,
        TS_OR_SRC      = 3'h2,
        TS_UNATT_SNK   = 3'h6,
        TS_ATTWAIT_SNK = 3'h7,
        TS_DBG_SNK     = 3'h5
    } dda_ts_state_t;

    function automatic logic termIsRd(input dda_term_t t);
        termIsRd = (t == TERM_RD) || (t == TERM_RD_ALT);
    endfunction : termIsRd

    function automatic logic termIsRp(input dda_term_t t);
        termIsRp = (t == TERM_RP_DEF) || (t == TERM_RP_1A5) || (t == TERM_RP_3A0);
    endfunction : termIsRp

    function automatic logic [1:0] termCurrent(input dda_term_t t);
        case (t)
            TERM_RP_DEF: termCurrent = CUR_DEF;
            TERM_RP_1A5: termCurrent = CUR_1A5;
            TERM_RP_3A0: termCurrent = CUR_3A0;
            default:     termCurrent = CUR_NONE;
        endcase
    endfunction : termCurrent

    function automatic dda_term_t rpForLevel(input logic [1:0] lvl);
        case (lvl)
            CUR_1A5: rpForLevel = TERM_RP_1A5;
            CUR_3A0: rpForLevel = TERM_RP_3A0;
            default: rpForLevel = TERM_RP_DEF;
        endcase
    endfunction : rpForLevel

endpackage : dda_pkg

// file: include/dda_link_if.sv
`timescale 1ns/1ps
interface dda_link_if;
    import dda_pkg::*;

    // Index 0 is CC1, index 1 is CC2.
    dda_term_t [1:0] dtsTerm;
    dda_term_t [1:0] tsTerm;
    logic            dtsVbusEn;
    logic            tsVbusEn;

    modport dts (output dtsTerm, output dtsVbusEn, input tsTerm, input tsVbusEn);
    modport ts  (output tsTerm, output tsVbusEn, input dtsTerm, input dtsVbusEn);
endinterface : dda_link_if

// file: design/dda_ts_end.sv
`timescale 1ns/1ps
module dda_ts_end
    import dda_pkg::*;
#(
    parameter int unsigned CC_DEB_CYC = CC_DEBOUNCE_CYC,
    parameter int unsigned TOGGLE_LEN = TOGGLE_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Link
    dda_link_if.ts           link,
    // User side
    input  wire logic        isDrp,
    input  wire logic        orientEn,
    input  wire logic [1:0]  rpLevel,
    output logic             attached,
    output logic             sourceRole,
    output logic [2:0]       stateCode,
    output logic [1:0]       advCurrent,
    output logic             orientFlip
);

    if (CC_DEB_CYC < 1 || TOGGLE_LEN < 1)
    begin : g_chk
        $error("dda_ts_end: timing counts must be at least one cycle");
    end

    dda_term_t [1:0] farMeta_q, farSync_q;
    logic            vbusMeta_q, vbusSync_q;
    dda_term_t [1:0] far;
    dda_ts_state_t   state_q, state_d;
    logic [31:0]     stateTmr_q, stateTmr_d, stableTmr_q, stableTmr_d;
    dda_term_t [1:0] term_q, term_d;
    logic            vbus_q, vbus_d, flip_q, flip_d;
    logic [1:0]      cur_q, cur_d;
    logic            bothRd, bothRp, noRd, srcSide;
    dda_ts_state_t   homeState;

    always_ff @(posedge ref_clk)
    begin
        farMeta_q  <= link.dtsTerm;
        farSync_q  <= farMeta_q;
        vbusMeta_q <= link.dtsVbusEn;
        vbusSync_q <= vbusMeta_q;
    end

    assign far       = farSync_q;
    assign bothRd    = termIsRd(far[0]) && termIsRd(far[1]);
    assign bothRp    = termIsRp(far[0]) && termIsRp(far[1]);
    assign noRd      = !termIsRd(far[0]) && !termIsRd(far[1]);
    assign homeState = isDrp ? TS_UNATT_SNK : TS_UNATT_SRC;

    always_comb
    begin
        state_d     = state_q;
        flip_d      = flip_q;
        stateTmr_d  = (stateTmr_q == 32'hffffffff) ? stateTmr_q : stateTmr_q + 32'h1;
        srcSide     = (state_q == TS_UNATT_SRC) || (state_q == TS_ATTWAIT_SRC);
        stableTmr_d = (srcSide ? bothRd : bothRp) ? stableTmr_q + 32'h1 : 32'h0;
        case (state_q)
            TS_UNATT_SRC:
                if (bothRd)
                    state_d = TS_ATTWAIT_SRC;
                else if (isDrp && stateTmr_q >= TOGGLE_LEN)
                    state_d = TS_UNATT_SNK;
            TS_ATTWAIT_SRC:
                if (!bothRd)
                    state_d = TS_UNATT_SRC;
                else if (stableTmr_q >= CC_DEB_CYC)
                    state_d = TS_UNOR_SRC;
            TS_UNOR_SRC:
                if (noRd)
                    state_d = homeState;
                else if (orientEn && (far[0] == TERM_RD_ALT) != (far[1] == TERM_RD_ALT))
                begin
                    state_d = TS_OR_SRC;
                    flip_d  = (far[0] == TERM_RD_ALT);
                end
            TS_OR_SRC:
                if (noRd)
                    state_d = homeState;
            TS_UNATT_SNK:
                if (bothRp)
                    state_d = TS_ATTWAIT_SNK;
                else if (stateTmr_q >= TOGGLE_LEN)
                    state_d = TS_UNATT_SRC;
            TS_ATTWAIT_SNK:
                if (!bothRp)
                    state_d = TS_UNATT_SNK;
                else if (stableTmr_q >= CC_DEB_CYC && vbusSync_q)
                    state_d = TS_DBG_SNK;
            TS_DBG_SNK:
                if (!vbusSync_q)
                    state_d = TS_UNATT_SNK;
            default:
                state_d = TS_UNATT_SRC;
        endcase
        if (state_d != state_q)
        begin
            stateTmr_d  = 32'h0;
            stableTmr_d = 32'h0;
        end
        if (state_d != TS_OR_SRC && state_d != TS_DBG_SNK)
            flip_d = 1'b0;
        // The debug sink follows the stronger advertisement and orients toward it.
        cur_d = CUR_NONE;
        if (state_d == TS_DBG_SNK)
        begin
            cur_d  = (termCurrent(far[1]) > termCurrent(far[0])) ? termCurrent(far[1]) : termCurrent(far[0]);
            flip_d = termCurrent(far[1]) > termCurrent(far[0]);
        end
        vbus_d = (state_d == TS_UNOR_SRC) || (state_d == TS_OR_SRC);
        case (state_d)
            TS_UNATT_SNK, TS_ATTWAIT_SNK, TS_DBG_SNK:
                term_d = '{TERM_RD, TERM_RD};
            default:
                term_d = '{rpForLevel(rpLevel), rpForLevel(rpLevel)};
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_q     <= TS_UNATT_SRC;
            stateTmr_q  <= 32'h0;
            stableTmr_q <= 32'h0;
            term_q      <= '{TERM_OPEN, TERM_OPEN};
            vbus_q      <= 1'b0;
            flip_q      <= 1'b0;
            cur_q       <= CUR_NONE;
        end
        else
        begin
            state_q     <= state_d;
            stateTmr_q  <= stateTmr_d;
            stableTmr_q <= stableTmr_d;
            term_q      <= term_d;
            vbus_q      <= vbus_d;
            flip_q      <= flip_d;
            cur_q       <= cur_d;
        end
    end

    assign link.tsTerm   = term_q;
    assign link.tsVbusEn = vbus_q;
    assign attached      = (state_q == TS_UNOR_SRC) || (state_q == TS_OR_SRC) || (state_q == TS_DBG_SNK);
    assign sourceRole    = !term_q[0][2] ? 1'b0 : 1'b1;
    assign stateCode     = state_q;
    assign advCurrent    = cur_q;
    assign orientFlip    = flip_q;

endmodule : dda_ts_end

// file: design/dda_dts_end.sv
`timescale 1ns/1ps
module dda_dts_end
    import dda_pkg::*;
#(
    parameter int unsigned CC_DEB_CYC = CC_DEBOUNCE_CYC,
    parameter int unsigned PD_DEB_CYC = PD_DEBOUNCE_CYC,
    parameter int unsigned TRY_CYC    = DRP_TRY_CYC,
    parameter int unsigned TOGGLE_LEN = TOGGLE_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Link
    dda_link_if.dts          link,
    // User side: configuration
    input  wire logic [1:0]  rpLevel,
    input  wire logic        orientEn,
    input  wire logic        ccCommSel,
    // User side: status
    output logic             attached,
    output logic             sourceRole,
    output logic [2:0]       stateCode,
    output logic [1:0]       advCurrent,
    output logic             vbusOn
);

    if (CC_DEB_CYC < 1 || PD_DEB_CYC < 1 || TRY_CYC < 1 || TOGGLE_LEN < 1)
    begin : g_chk
        $error("dda_dts_end: timing counts must be at least one cycle");
    end

    dda_term_t [1:0] farMeta_q, farSync_q;
    logic            vbusMeta_q, vbusSync_q;
    dda_term_t [1:0] far;
    dda_dts_state_t  state_q, state_d;
    logic [31:0]     stateTmr_q, stateTmr_d, stableTmr_q, stableTmr_d;
    dda_term_t [1:0] term_q, term_d;
    logic            vbus_q, vbus_d;
    logic [1:0]      cur_q, cur_d;
    logic            bothRd, bothRp, srcSide;
    dda_term_t       rpTerm;

    // Pins come from another device, so both the CC levels and VBUS are
    // synchronised before any decision looks at them.
    always_ff @(posedge ref_clk)
    begin
        farMeta_q  <= link.tsTerm;
        farSync_q  <= farMeta_q;
        vbusMeta_q <= link.tsVbusEn;
        vbusSync_q <= vbusMeta_q;
    end

    assign far    = farSync_q;
    assign bothRd = termIsRd(far[0]) && termIsRd(far[1]);
    assign bothRp = termIsRp(far[0]) && termIsRp(far[1]);
    assign rpTerm = rpForLevel(rpLevel);

    // The state timer stops at its ceiling rather than wrapping, so a very long
    // stay in one state can never look like a fresh entry to the timeouts.
    function automatic logic [31:0] satInc(input logic [31:0] v);
        satInc = (v == 32'hffffffff) ? v : v + 32'h1;
    endfunction : satInc

    always_comb
    begin
        state_d     = state_q;
        stateTmr_d  = satInc(stateTmr_q);
        srcSide     = (state_q == DTS_UNATT_SRC) || (state_q == DTS_ATTWAIT_SRC)
                   || (state_q == DTS_ATT_SRC) || (state_q == DTS_TRY_SRC);
        // The stability counter restarts on any glitch, which is what makes it
        // a debounce rather than a plain delay.
        stableTmr_d = (srcSide ? bothRd : bothRp) ? stableTmr_q + 32'h1 : 32'h0;
        case (state_q)
            DTS_UNATT_SRC:
                if (bothRd)
                    state_d = DTS_ATTWAIT_SRC;
                else if (stateTmr_q >= TOGGLE_LEN)
                    state_d = DTS_UNATT_SNK;
            DTS_ATTWAIT_SRC:
                if (!bothRd)
                    state_d = DTS_UNATT_SNK;
                else if (stableTmr_q >= CC_DEB_CYC)
                    state_d = DTS_ATT_SRC;
            DTS_ATT_SRC:
                if (!bothRd)
                    state_d = DTS_UNATT_SNK;
            DTS_UNATT_SNK:
                if (bothRp)
                    state_d = DTS_ATTWAIT_SNK;
                else if (stateTmr_q >= TOGGLE_LEN)
                    state_d = DTS_UNATT_SRC;
            DTS_ATTWAIT_SNK:
                if (!bothRp)
                    state_d = DTS_UNATT_SNK;
                else if (stableTmr_q >= CC_DEB_CYC && vbusSync_q)
                    state_d = DTS_TRY_SRC;
            DTS_TRY_SRC:
                if (stableTmr_q >= PD_DEB_CYC)
                    state_d = DTS_ATT_SRC;
                else if (stateTmr_q >= TRY_CYC && !bothRd)
                    state_d = DTS_TRYWAIT_SNK;
            DTS_TRYWAIT_SNK:
                if (stableTmr_q >= CC_DEB_CYC && vbusSync_q)
                    state_d = DTS_ATT_SNK;
                else if (stateTmr_q >= TRY_CYC && !bothRp)
                    state_d = DTS_UNATT_SNK;
            DTS_ATT_SNK:
                if (!vbusSync_q)
                    state_d = DTS_UNATT_SNK;
            default:
                state_d = DTS_UNATT_SRC;
        endcase
        if (state_d != state_q)
        begin
            stateTmr_d  = 32'h0;
            stableTmr_d = 32'h0;
        end

        // VBUS is driven only in the attached source state, so every exit from
        // it, and the whole try step, leaves the switch open.
        vbus_d = (state_d == DTS_ATT_SRC);

        // Each pin is set on its own, so the enum type of every element is kept
        // and no untyped vector is ever forced into the termination code.
        case (state_d)
            DTS_UNATT_SRC, DTS_ATTWAIT_SRC, DTS_TRY_SRC:
            begin
                term_d[0] = rpTerm;
                term_d[1] = rpTerm;
            end
            DTS_ATT_SRC:
            begin
                term_d[0] = rpTerm;
                term_d[1] = rpTerm;
            end
            DTS_ATT_SNK:
            begin
                // The pin not used for communication carries the altered Rd, so
                // the far source can tell which way round the plug sits.
                term_d[0] = (orientEn && ccCommSel) ? TERM_RD_ALT : TERM_RD;
                term_d[1] = (orientEn && !ccCommSel) ? TERM_RD_ALT : TERM_RD;
            end
            default:
            begin
                term_d[0] = TERM_RD;
                term_d[1] = TERM_RD;
            end
        endcase

        // Without orientation either pin advertises the same current; pin 0
        // is read then, so a mismatch between pins goes unnoticed.
        cur_d = CUR_NONE;
        if (state_d == DTS_ATT_SNK)
            cur_d = (orientEn && ccCommSel) ? termCurrent(far[1]) : termCurrent(far[0]);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_q     <= DTS_UNATT_SRC;
            stateTmr_q  <= 32'h0;
            stableTmr_q <= 32'h0;
            term_q      <= '{TERM_OPEN, TERM_OPEN};
            vbus_q      <= 1'b0;
            cur_q       <= CUR_NONE;
        end
        else
        begin
            state_q     <= state_d;
            stateTmr_q  <= stateTmr_d;
            stableTmr_q <= stableTmr_d;
            term_q      <= term_d;
            vbus_q      <= vbus_d;
            cur_q       <= cur_d;
        end
    end

    // stateCode, advCurrent and vbusOn come straight from a flop, attached and sourceRole from a decode of flops, so the user
    // side never sees the next-state logic while the state and its timers move together.
    // The role follows the termination actually shown, not the state code.
    assign link.dtsTerm   = term_q;
    assign link.dtsVbusEn = vbus_q;
    assign attached       = (state_q == DTS_ATT_SRC) || (state_q == DTS_ATT_SNK);
    assign sourceRole     = termIsRp(term_q[0]);
    assign stateCode      = state_q;
    assign advCurrent     = cur_q;
    assign vbusOn         = vbus_q;

endmodule : dda_dts_end

// file: test/dda_link_props.sv
`timescale 1ns/1ps
module dda_link_props
    import dda_pkg::*;
(
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            reset_n,
    // Link levels
    input wire dda_term_t [1:0] dtsTerm,
    input wire dda_term_t [1:0] tsTerm,
    input wire logic            dtsVbusEn,
    input wire logic            tsVbusEn
);
    logic tsBothRd;
    logic dtsBothRd;
    logic dtsAnyRd;
    logic tsBothRp;
    logic dtsBothRp;
    logic dtsAltSeen;

    assign tsBothRd   = (tsTerm[0] inside {TERM_RD, TERM_RD_ALT}) && (tsTerm[1] inside {TERM_RD, TERM_RD_ALT});
    assign dtsBothRd  = (dtsTerm[0] inside {TERM_RD, TERM_RD_ALT}) && (dtsTerm[1] inside {TERM_RD, TERM_RD_ALT});
    assign dtsAnyRd   = (dtsTerm[0] inside {TERM_RD, TERM_RD_ALT}) || (dtsTerm[1] inside {TERM_RD, TERM_RD_ALT});
    assign tsBothRp   = (tsTerm[0] inside {TERM_RP_DEF, TERM_RP_1A5, TERM_RP_3A0})
                        && (tsTerm[1] inside {TERM_RP_DEF, TERM_RP_1A5, TERM_RP_3A0});
    assign dtsBothRp  = (dtsTerm[0] inside {TERM_RP_DEF, TERM_RP_1A5, TERM_RP_3A0})
                        && (dtsTerm[1] inside {TERM_RP_DEF, TERM_RP_1A5, TERM_RP_3A0});
    assign dtsAltSeen = (dtsTerm[0] == TERM_RD_ALT) || (dtsTerm[1] == TERM_RD_ALT);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Far-end levels reach the state logic through two flops, so causes sit three samples back.
    a_src_vbus_debounced: assert property ($rose(dtsVbusEn) |-> $past(tsBothRd, 3) && $past(tsBothRd, 8))
        else $error("source power switched on without settled pull-downs");
    a_src_detach_drop: assert property (dtsVbusEn && !tsBothRd |-> ##[1:4] !dtsVbusEn)
        else $error("source power kept after a pull-down vanished");
    a_src_rp_level: assert property (dtsVbusEn |-> dtsBothRp && (dtsTerm[0] == dtsTerm[1]))
        else $error("powered source does not offer one current on both pins");
    a_ts_vbus_debounced: assert property ($rose(tsVbusEn) |-> $past(dtsBothRd, 3) && $past(dtsBothRd, 8))
        else $error("far source powered up without settled pull-downs");
    a_ts_detach_drop: assert property (tsVbusEn && !dtsAnyRd |-> ##[1:4] !tsVbusEn)
        else $error("far source kept power after both pull-downs left");
    a_ts_rp_level: assert property (tsVbusEn |-> tsBothRp)
        else $error("far source powered without pull-ups");
    a_orient_needs_vbus: assert property (dtsAltSeen |-> $past(tsVbusEn, 3))
        else $error("orientation mark shown without power present");
    a_orient_one_pin: assert property (dtsAltSeen |-> (dtsTerm[0] == TERM_RD) || (dtsTerm[1] == TERM_RD))
        else $error("orientation mark not confined to one pin");
endmodule : dda_link_props

// file: test/debug_drp_attach_fsm_test.sv
`timescale 1ns/1ps
module debug_drp_attach_fsm_test;
    import dda_pkg::*;

    localparam int CC_T     = 40;
    localparam int PD_T     = 10;
    localparam int TRY_T    = 30;
    localparam int TIME_CAP = 10000;

    logic       ref_clk;
    logic       reset_n;
    logic [1:0] rpLevelA, rpLevelB, rpLevelT;
    logic       orientA, orientB, orientT, commSelA, commSelB, isDrp;
    logic       attA, attB, attT, srcA, srcB, srcT, flipT, vbusA, vbusB;
    logic [2:0] codeA, codeB, codeT;
    logic [1:0] curA, curB, curT;
    logic [2:0] codes [0:2];
    int         error_cnt = 0;
    int         comparisons = 0;
    int         cycles = 0;

    dda_link_if linkA ();
    dda_link_if linkB ();

    dda_dts_end #(.CC_DEB_CYC(CC_T), .PD_DEB_CYC(PD_T), .TRY_CYC(TRY_T), .TOGGLE_LEN(100)) u_dda_dts_end (
        .ref_clk(ref_clk), .reset_n(reset_n), .link(linkA.dts), .rpLevel(rpLevelA), .orientEn(orientA),
        .ccCommSel(commSelA), .attached(attA), .sourceRole(srcA), .stateCode(codeA), .advCurrent(curA),
        .vbusOn(vbusA));
    dda_ts_end #(.CC_DEB_CYC(CC_T), .TOGGLE_LEN(70)) u_dda_ts_end (
        .ref_clk(ref_clk), .reset_n(reset_n), .link(linkA.ts), .isDrp(isDrp), .orientEn(orientT),
        .rpLevel(rpLevelT), .attached(attT), .sourceRole(srcT), .stateCode(codeT), .advCurrent(curT),
        .orientFlip(flipT));
    // The second end faces the bench, which plays the far port and can misbehave at will.
    dda_dts_end #(.CC_DEB_CYC(CC_T), .PD_DEB_CYC(PD_T), .TRY_CYC(TRY_T), .TOGGLE_LEN(100)) u_dda_dts_end_b (
        .ref_clk(ref_clk), .reset_n(reset_n), .link(linkB.dts), .rpLevel(rpLevelB), .orientEn(orientB),
        .ccCommSel(commSelB), .attached(attB), .sourceRole(srcB), .stateCode(codeB), .advCurrent(curB),
        .vbusOn(vbusB));
    dda_link_props u_dda_link_props (
        .ref_clk(ref_clk), .reset_n(reset_n), .dtsTerm(linkA.dtsTerm), .tsTerm(linkA.tsTerm),
        .dtsVbusEn(linkA.dtsVbusEn), .tsVbusEn(linkA.tsVbusEn));

    always_comb
    begin
        codes[0] = codeB;
        codes[1] = codeA;
        codes[2] = codeT;
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons: %0d, mismatches: %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == TIME_CAP)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Waits a bounded number of cycles for a state code; a miss shows as a mismatch.
    task automatic reach(input int sel, input logic [2:0] code, input int lim, output int took);
        took = 0;
        while (codes[sel] !== code && took < lim)
        begin
            @(negedge ref_clk);
            took++;
        end
        check(8'(codes[sel]), 8'(code));
    endtask : reach

    task automatic doReset(input logic drp);
        @(negedge ref_clk);
        reset_n = 1'b0;
        isDrp = drp;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
    endtask : doReset

    task automatic driveTs(input dda_term_t cc1, input dda_term_t cc2, input logic vb);
        @(negedge ref_clk);
        linkB.tsTerm[0] = cc1;
        linkB.tsTerm[1] = cc2;
        linkB.tsVbusEn = vb;
    endtask : driveTs

    initial
    begin
        int n;
        reset_n = 1'b0;
        isDrp = 1'b1;
        rpLevelA = 2'h2;
        rpLevelB = 2'h2;
        rpLevelT = 2'h1;
        orientA = 1'b1;
        orientB = 1'b1;
        orientT = 1'b1;
        commSelA = 1'b1;
        commSelB = 1'b0;
        linkB.tsTerm[0] = TERM_OPEN;
        linkB.tsTerm[1] = TERM_OPEN;
        linkB.tsVbusEn = 1'b0;
        doReset(1'b1);
        reach(0, DTS_UNATT_SRC, 5, n);
        @(negedge ref_clk);
        check(8'(linkB.dtsTerm[0]), 8'(TERM_RP_1A5));
        reach(0, DTS_UNATT_SNK, 110, n);
        check(8'(n >= 98), 8'h01);
        check(8'(linkB.dtsTerm[1]), 8'(TERM_RD));
        rpLevelB = 2'h3;
        driveTs(TERM_RD, TERM_RD, 1'b0);
        reach(0, DTS_ATTWAIT_SRC, 120, n);
        reach(0, DTS_ATT_SRC, CC_T + 10, n);
        check(8'(n >= CC_T - 2), 8'h01);
        check(8'(vbusB), 8'h01);
        check(8'(attB), 8'h01);
        check(8'(srcB), 8'h01);
        check(8'(linkB.dtsTerm[1]), 8'(TERM_RP_3A0));
        driveTs(TERM_RD, TERM_OPEN, 1'b0);
        reach(0, DTS_UNATT_SNK, 6, n);
        check(8'(vbusB), 8'h00);
        driveTs(TERM_RP_DEF, TERM_RP_DEF, 1'b1);
        reach(0, DTS_ATTWAIT_SNK, 6, n);
        reach(0, DTS_TRY_SRC, CC_T + 10, n);
        check(8'(vbusB), 8'h00);
        driveTs(TERM_RD, TERM_RD, 1'b0);
        reach(0, DTS_ATT_SRC, PD_T + 8, n);
        check(8'(n >= PD_T), 8'h01);
        check(8'(vbusB), 8'h01);
        driveTs(TERM_OPEN, TERM_OPEN, 1'b0);
        reach(0, DTS_UNATT_SNK, 6, n);
        // The bench keeps its pull-ups through the try, so the try must time out.
        driveTs(TERM_RP_3A0, TERM_RP_1A5, 1'b1);
        reach(0, DTS_TRY_SRC, 2 * CC_T, n);
        reach(0, DTS_TRYWAIT_SNK, TRY_T + 6, n);
        check(8'(n >= TRY_T - 2), 8'h01);
        reach(0, DTS_ATT_SNK, CC_T + 8, n);
        repeat (2) @(negedge ref_clk);
        check(8'(linkB.dtsTerm[1]), 8'(TERM_RD_ALT));
        check(8'(curB), 8'(CUR_3A0));
        check(8'(srcB), 8'h00);
        driveTs(TERM_RP_DEF, TERM_RP_3A0, 1'b1);
        repeat (5) @(negedge ref_clk);
        check(8'(curB), 8'(CUR_DEF));
        driveTs(TERM_RP_DEF, TERM_RP_3A0, 1'b0);
        reach(0, DTS_UNATT_SNK, 6, n);
        reach(1, DTS_ATT_SRC, 2000, n);
        reach(2, TS_DBG_SNK, 200, n);
        check(8'(curT), 8'(CUR_1A5));
        check(8'(attT), 8'h01);
        check(8'(vbusA), 8'h01);
        doReset(1'b0);
        reach(1, DTS_ATT_SNK, 2000, n);
        reach(2, TS_OR_SRC, 20, n);
        check(8'(flipT), 8'h01);
        check(8'(srcT), 8'h01);
        check(8'(attA), 8'h01);
        check(8'(curA), 8'(CUR_DEF));
        tally_and_finish();
    end
endmodule : debug_drp_attach_fsm_test
